/* rtl/sbsi_pkg.sv */
package sbsi_pkg;
	// organisation: x18, two byte lanes of nine bits
	localparam int ADDR_W = 23;
	localparam int DATA_W = 18;
	localparam int LANES = 2;
	localparam int LANE_W = 9;
	localparam int BURST_W = 2;
	// implemented storage words; upper address bits alias onto them
	localparam int STORE_AW = 8;
	localparam int STORE_WORDS = 256;

	// defaults that apply when a mode pin is left undriven
	localparam logic DEF_FT_N = 1'h1;
	localparam logic DEF_LBO_N = 1'h1;
	localparam logic DEF_SCD = 1'h1;

	// read capture delay in the controller, in cycles after the beat
	localparam logic [2:0] LAT_FT = 3'h1;
	localparam logic [2:0] LAT_PIPE = 3'h2;

	// controller register byte offsets
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_ADDR = 5'h04;
	localparam logic [4:0] OFS_CMD = 5'h08;
	localparam logic [4:0] OFS_STATUS = 5'h0c;
	localparam logic [4:0] OFS_DATA = 5'h10;

	// control register fields
	localparam int CTRL_W = 7;
	localparam int CTRL_FT_N = 0;
	localparam int CTRL_FT_DRV = 1;
	localparam int CTRL_LBO_N = 2;
	localparam int CTRL_LBO_DRV = 3;
	localparam int CTRL_SCD = 4;
	localparam int CTRL_SCD_DRV = 5;
	localparam int CTRL_SLEEP = 6;

	// command register fields
	localparam int CMD_W = 10;
	localparam int CMD_WRITE = 0;
	localparam int CMD_GLOBAL = 1;
	localparam int CMD_CTRL_STB = 2;
	localparam int CMD_LEN = 4;
	localparam int CMD_LANES = 8;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic [1:0] {
		SBSI_IDLE = 2'b00,
		SBSI_ISSUE = 2'b01,
		SBSI_WAIT = 2'b10
	} sbsi_hstate_t;
endpackage

/* rtl/sbsi_if.sv */
`timescale 1ns/100ps
interface sbsi_if;
	logic [sbsi_pkg::ADDR_W-1:0] addr;
	logic chip_select_n;
	logic proc_addr_strobe_n;
	logic ctrl_addr_strobe_n;
	logic burst_advance_n;
	logic [sbsi_pkg::LANES-1:0] byte_lane_write_sel_n;
	logic byte_write_enable_n;
	logic global_write_n;
	logic output_enable_n;
	logic sleep_control;
	logic flow_through_sel_n;
	logic flow_through_drv;
	logic linear_order_sel_n;
	logic linear_order_drv;
	logic deselect_mode_sel;
	logic deselect_mode_drv;
	logic [sbsi_pkg::DATA_W-1:0] host_dq_out;
	logic host_dq_oe_n;
	logic [sbsi_pkg::DATA_W-1:0] dev_dq_out;
	logic dev_dq_oe_n;
	logic [sbsi_pkg::DATA_W-1:0] dq;

	// resolved data wire; an undriven bus reads as zero
	assign dq = !dev_dq_oe_n ? dev_dq_out : (!host_dq_oe_n ? host_dq_out : '0);

	modport device (
		input addr, chip_select_n, proc_addr_strobe_n, ctrl_addr_strobe_n,
		input burst_advance_n, byte_lane_write_sel_n, byte_write_enable_n,
		input global_write_n, output_enable_n, sleep_control,
		input flow_through_sel_n, flow_through_drv, linear_order_sel_n,
		input linear_order_drv, deselect_mode_sel, deselect_mode_drv, dq,
		output dev_dq_out, dev_dq_oe_n
	);
	modport host (
		output addr, chip_select_n, proc_addr_strobe_n, ctrl_addr_strobe_n,
		output burst_advance_n, byte_lane_write_sel_n, byte_write_enable_n,
		output global_write_n, output_enable_n, sleep_control,
		output flow_through_sel_n, flow_through_drv, linear_order_sel_n,
		output linear_order_drv, deselect_mode_sel, deselect_mode_drv,
		output host_dq_out, host_dq_oe_n,
		input dq
	);
endinterface

/* rtl/sbsi_burst_ctr.sv */
`timescale 1ns/100ps
module sbsi_burst_ctr (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic load,
	input wire logic advance,
	input wire logic linear,
	input wire logic [sbsi_pkg::BURST_W-1:0] preset,
	output logic [sbsi_pkg::BURST_W-1:0] lsb
);
	typedef struct packed {
		logic [sbsi_pkg::BURST_W-1:0] start;
		logic [sbsi_pkg::BURST_W-1:0] cnt;
	} sbsi_ctr_t;

	sbsi_ctr_t s;
	sbsi_ctr_t next_s;
	logic [sbsi_pkg::BURST_W-1:0] cnt_now;

	// burst order: linear adds the step, interleaved xors it
	function automatic logic [sbsi_pkg::BURST_W-1:0] order(
		input logic [sbsi_pkg::BURST_W-1:0] base,
		input logic [sbsi_pkg::BURST_W-1:0] step,
		input logic lin
	);
		order = lin ? base + step : base ^ step;
	endfunction

	// address lsbs used in this very cycle, so an advance costs no latency
	always_comb begin
		next_s = s;
		cnt_now = advance ? s.cnt + 2'h1 : s.cnt;
		if (load) begin
			lsb = preset;
			next_s.start = preset;
			next_s.cnt = '0;
		end else begin
			lsb = order(s.start, cnt_now, linear);
			next_s.cnt = cnt_now;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule

/* rtl/sbsi_device.sv */
`timescale 1ns/100ps
// Contract
// - synchronous inputs sampled on rising clock edge
// - output enable and sleep act asynchronously
// - either address strobe starts a burst
// - counter steps only when advance asserted
// - burst counter is two bits wide
// - linear order when selected, else interleaved
// - new address accepted every cycle
// - flow-through bypasses output register
// - pipeline mode adds one output register
// - dual deselect pipelined like reads; code turns output off one cycle later than read data turns on
// - single deselect one stage less; code turns output off with the same latency as reads
// - single deselect turns outputs off promptly
// - dual deselect held one extra cycle
// - system sets deselect mode statically
// - byte write enable writes selected lanes
// - global write writes every lane
// - undriven mode pins take defaults
// - organisation x18 with per-lane write selects
// - write self-timed once captured
// - advance, writes, chip select low; sleep high
// - address lsbs preset the burst counter
module sbsi_device (
	input wire logic hclk,
	input wire logic hresetn,
	sbsi_if.device bus
);
	typedef struct packed {
		logic burst_on;
		logic [sbsi_pkg::ADDR_W-3:0] base;
		logic rd1;
		logic ds1;
		logic drive;
		logic [sbsi_pkg::DATA_W-1:0] pipe;
		logic [sbsi_pkg::DATA_W-1:0] dout;
	} sbsi_dev_t;

	sbsi_dev_t s;
	sbsi_dev_t next_s;

	logic ft_mode;
	logic linear_mode;
	logic single_desel;
	logic awake;
	logic strobe;
	logic start;
	logic desel;
	logic cont;
	logic active;
	logic wr;
	logic rd;
	logic [sbsi_pkg::LANES-1:0] lanes;
	logic [sbsi_pkg::BURST_W-1:0] lsb;
	logic [sbsi_pkg::ADDR_W-1:0] eff_addr;
	logic [sbsi_pkg::STORE_AW-1:0] idx;
	logic [sbsi_pkg::DATA_W-1:0] rd_word;

	// a floating mode pin reads as its default, like an internal pull
	always_comb begin
		ft_mode = (bus.flow_through_drv ? bus.flow_through_sel_n
			: sbsi_pkg::DEF_FT_N) == 1'h0;
		linear_mode = (bus.linear_order_drv ? bus.linear_order_sel_n
			: sbsi_pkg::DEF_LBO_N) == 1'h0;
		single_desel = bus.deselect_mode_drv ? bus.deselect_mode_sel
			: sbsi_pkg::DEF_SCD;
	end

	// command decode for the cycle that ends at the next rising edge
	always_comb begin
		awake = !bus.sleep_control;
		strobe = !bus.proc_addr_strobe_n || !bus.ctrl_addr_strobe_n;
		start = awake && strobe && !bus.chip_select_n;
		desel = awake && strobe && bus.chip_select_n;
		cont = awake && !strobe && s.burst_on;
		active = start || cont;
		if (!bus.global_write_n) begin
			lanes = '1;
		end else if (!bus.byte_write_enable_n) begin
			lanes = ~bus.byte_lane_write_sel_n;
		end else begin
			lanes = '0;
		end
		wr = active && (lanes != '0);
		rd = active && !wr;
	end

	sbsi_burst_ctr u_ctr (
		.hclk(hclk),
		.hresetn(hresetn),
		.load(start),
		.advance(cont && !bus.burst_advance_n),
		.linear(linear_mode),
		.preset(bus.addr[sbsi_pkg::BURST_W-1:0]),
		.lsb(lsb)
	);

	// the upper address comes from the pins on a load, else from the burst base
	always_comb begin
		eff_addr = {start ? bus.addr[sbsi_pkg::ADDR_W-1:sbsi_pkg::BURST_W] : s.base, lsb};
		idx = eff_addr[sbsi_pkg::STORE_AW-1:0];
	end

	// one storage array per lane, so each lane write select acts alone
	generate
		for (genvar i = 0; i < sbsi_pkg::LANES; i++) begin : g_lane
			logic [sbsi_pkg::LANE_W-1:0] store [sbsi_pkg::STORE_WORDS];

			// written at the capture edge itself; nothing for the master to hold
			always_ff @(posedge hclk) begin
				if (wr && lanes[i]) begin
					store[idx] <= bus.dq[i*sbsi_pkg::LANE_W +: sbsi_pkg::LANE_W];
				end
			end

			assign rd_word[i*sbsi_pkg::LANE_W +: sbsi_pkg::LANE_W] = store[idx];
		end
	endgenerate

	// burst tracking, read data path and output-drive pipeline
	always_comb begin
		next_s = s;
		if (start) begin
			next_s.burst_on = 1'h1;
			next_s.base = bus.addr[sbsi_pkg::ADDR_W-1:sbsi_pkg::BURST_W];
		end else if (desel || !awake) begin
			next_s.burst_on = 1'h0; // sleep also drops an open burst
		end
		next_s.rd1 = rd;
		next_s.ds1 = desel || !awake;
		if (rd) begin
			next_s.pipe = rd_word;
		end
		// flow-through: array word goes out at the access edge
		// pipeline: it waits one more edge in the output register
		if (ft_mode) begin
			if (rd) begin
				next_s.dout = rd_word;
			end
		end else if (s.rd1) begin
			next_s.dout = s.pipe;
		end
		// single mode drops the drive as soon as no read feeds it;
		// dual mode keeps it one extra cycle after a captured deselect,
		// which holds the bus longer but eases turnaround for slow masters
		if (ft_mode) begin
			if (single_desel) begin
				next_s.drive = rd;
			end else begin
				next_s.drive = rd || (s.drive && desel);
			end
		end else begin
			if (single_desel) begin
				next_s.drive = s.rd1;
			end else begin
				next_s.drive = s.rd1 || (s.drive && s.ds1);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// enable and sleep gate the drivers without waiting for a clock edge
	assign bus.dev_dq_oe_n = !(s.drive && !bus.output_enable_n && !bus.sleep_control);
	assign bus.dev_dq_out = s.dout;
endmodule

/* rtl/sbsi_host.sv */
`timescale 1ns/100ps
module sbsi_host (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	sbsi_if.host bus
);
	typedef struct packed {
		logic [sbsi_pkg::CTRL_W-1:0] ctrl;
		logic [sbsi_pkg::ADDR_W-1:0] addr;
		logic [sbsi_pkg::CMD_W-1:0] cmd;
		logic [3:0][sbsi_pkg::DATA_W-1:0] wdat;
		logic [3:0][sbsi_pkg::DATA_W-1:0] rdat;
		logic ap_wr;
		logic [4:0] ap_idx;
		logic [31:0] hrdata;
		sbsi_pkg::sbsi_hstate_t state;
		logic busy;
		logic [1:0] cyc;
		logic [2:0] t;
		logic [sbsi_pkg::ADDR_W-1:0] pin_addr;
		logic cs_n;
		logic pstb_n;
		logic cstb_n;
		logic adv_n;
		logic bw_n;
		logic gw_n;
		logic [sbsi_pkg::LANES-1:0] bsel_n;
		logic oe_n;
		logic [sbsi_pkg::DATA_W-1:0] dq_out;
		logic dq_oe_n;
	} sbsi_host_t;

	localparam sbsi_host_t RESET_S = '{state: sbsi_pkg::SBSI_IDLE, cs_n: 1'h1,
		pstb_n: 1'h1, cstb_n: 1'h1, adv_n: 1'h1, bw_n: 1'h1, gw_n: 1'h1,
		bsel_n: '1, oe_n: 1'h1, dq_oe_n: 1'h1, default: '0};

	sbsi_host_t s;
	sbsi_host_t next_s;
	logic [sbsi_pkg::CMD_W-1:0] cmd;
	logic go;
	logic present;
	logic [1:0] b;
	logic [2:0] lat;
	logic [2:0] ci;
	logic [2:0] len3;

	// register read decode; unmapped offsets read zero
	function automatic logic [31:0] reg_read(input sbsi_host_t r, input logic [4:0] a);
		reg_read = '0;
		if (a[4]) begin
			reg_read[sbsi_pkg::DATA_W-1:0] = r.rdat[a[3:2]];
		end else begin
			case (a)
				sbsi_pkg::OFS_CTRL: reg_read[sbsi_pkg::CTRL_W-1:0] = r.ctrl;
				sbsi_pkg::OFS_ADDR: reg_read[sbsi_pkg::ADDR_W-1:0] = r.addr;
				sbsi_pkg::OFS_CMD: reg_read[sbsi_pkg::CMD_W-1:0] = r.cmd;
				sbsi_pkg::OFS_STATUS: reg_read[0] = r.busy;
				default: reg_read = '0;
			endcase
		end
	endfunction

	always_comb begin
		next_s = s;
		go = 1'h0;
		present = 1'h0;
		b = '0;
		cmd = s.cmd;
		// bus slave: address phase captured, write data taken in data phase
		next_s.ap_wr = hsel && htrans[1] && hready && hwrite;
		next_s.ap_idx = haddr[4:0];
		if (hsel && htrans[1] && hready && !hwrite) begin
			next_s.hrdata = reg_read(s, haddr[4:0]);
		end
		if (s.ap_wr) begin
			if (s.ap_idx[4]) begin
				next_s.wdat[s.ap_idx[3:2]] = hwdata[sbsi_pkg::DATA_W-1:0];
			end else begin
				case (s.ap_idx)
					sbsi_pkg::OFS_CTRL: next_s.ctrl = hwdata[sbsi_pkg::CTRL_W-1:0];
					sbsi_pkg::OFS_ADDR: next_s.addr = hwdata[sbsi_pkg::ADDR_W-1:0];
					sbsi_pkg::OFS_CMD: begin
						// a command written while busy is dropped
						if (!s.busy) begin
							go = 1'h1;
							cmd = hwdata[sbsi_pkg::CMD_W-1:0];
							next_s.cmd = cmd;
						end
					end
					default: ;
				endcase
			end
		end
		lat = (s.ctrl[sbsi_pkg::CTRL_FT_DRV] && !s.ctrl[sbsi_pkg::CTRL_FT_N])
			? sbsi_pkg::LAT_FT : sbsi_pkg::LAT_PIPE;
		len3 = {1'h0, cmd[sbsi_pkg::CMD_LEN +: 2]};
		ci = s.t - lat;
		// every strobe, select and write pin returns to idle unless a beat or the closing deselect is presented; oe_n holds
		next_s.cs_n = 1'h1;
		next_s.pstb_n = 1'h1;
		next_s.cstb_n = 1'h1;
		next_s.adv_n = 1'h1;
		next_s.bw_n = 1'h1;
		next_s.gw_n = 1'h1;
		next_s.bsel_n = '1;
		next_s.dq_oe_n = 1'h1;
		case (s.state)
			sbsi_pkg::SBSI_IDLE: begin
				if (go) begin
					present = 1'h1;
					next_s.busy = 1'h1;
					next_s.cyc = '0;
					next_s.t = '0;
					next_s.oe_n = cmd[sbsi_pkg::CMD_WRITE];
					next_s.state = sbsi_pkg::SBSI_ISSUE;
				end
			end
			sbsi_pkg::SBSI_ISSUE: begin
				next_s.t = s.t + 3'h1;
				if ({1'h0, s.cyc} == len3) begin
					// close the burst with a deselect so the device lets go
					next_s.cstb_n = 1'h0;
					next_s.state = sbsi_pkg::SBSI_WAIT;
				end else begin
					present = 1'h1;
					b = s.cyc + 2'h1;
					next_s.cyc = b;
				end
			end
			sbsi_pkg::SBSI_WAIT: begin
				next_s.t = s.t + 3'h1;
				if (cmd[sbsi_pkg::CMD_WRITE] || s.t == len3 + lat) begin
					next_s.busy = 1'h0;
					next_s.oe_n = 1'h1;
					next_s.state = sbsi_pkg::SBSI_IDLE;
				end
			end
			default: next_s = RESET_S;
		endcase
		// beat presentation: strobe and address on the first, advance after
		if (present) begin
			next_s.cs_n = 1'h0;
			if (b == 2'h0) begin
				next_s.pin_addr = s.addr;
				next_s.pstb_n = cmd[sbsi_pkg::CMD_CTRL_STB];
				next_s.cstb_n = !cmd[sbsi_pkg::CMD_CTRL_STB];
			end else begin
				next_s.adv_n = 1'h0;
			end
			if (cmd[sbsi_pkg::CMD_WRITE]) begin
				next_s.gw_n = !cmd[sbsi_pkg::CMD_GLOBAL];
				next_s.bw_n = cmd[sbsi_pkg::CMD_GLOBAL];
				next_s.bsel_n = ~cmd[sbsi_pkg::CMD_LANES +: 2];
				next_s.dq_out = s.wdat[b];
				next_s.dq_oe_n = 1'h0;
			end
		end
		// read capture at the edge ending the cycle the data stands in
		if (s.busy && !s.cmd[sbsi_pkg::CMD_WRITE] && s.t >= lat && ci <= len3) begin
			next_s.rdat[ci[1:0]] = bus.dq;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= RESET_S;
		end else begin
			s <= next_s;
		end
	end

	// every pin is a flop; mode pins are static levels from the control word
	assign hreadyout = 1'h1;
	assign hresp = 1'h0;
	assign hrdata = s.hrdata;
	assign bus.addr = s.pin_addr;
	assign bus.chip_select_n = s.cs_n;
	assign bus.proc_addr_strobe_n = s.pstb_n;
	assign bus.ctrl_addr_strobe_n = s.cstb_n;
	assign bus.burst_advance_n = s.adv_n;
	assign bus.byte_lane_write_sel_n = s.bsel_n;
	assign bus.byte_write_enable_n = s.bw_n;
	assign bus.global_write_n = s.gw_n;
	assign bus.output_enable_n = s.oe_n;
	assign bus.sleep_control = s.ctrl[sbsi_pkg::CTRL_SLEEP];
	assign bus.flow_through_sel_n = s.ctrl[sbsi_pkg::CTRL_FT_N];
	assign bus.flow_through_drv = s.ctrl[sbsi_pkg::CTRL_FT_DRV];
	assign bus.linear_order_sel_n = s.ctrl[sbsi_pkg::CTRL_LBO_N];
	assign bus.linear_order_drv = s.ctrl[sbsi_pkg::CTRL_LBO_DRV];
	assign bus.deselect_mode_sel = s.ctrl[sbsi_pkg::CTRL_SCD];
	assign bus.deselect_mode_drv = s.ctrl[sbsi_pkg::CTRL_SCD_DRV];
	assign bus.host_dq_out = s.dq_out;
	assign bus.host_dq_oe_n = s.dq_oe_n;
endmodule

/* tb/sbsi_checker.sv */
`timescale 1ns/100ps
module sbsi_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic chip_select_n,
	input wire logic proc_addr_strobe_n,
	input wire logic ctrl_addr_strobe_n,
	input wire logic [sbsi_pkg::LANES-1:0] byte_lane_write_sel_n,
	input wire logic byte_write_enable_n,
	input wire logic global_write_n,
	input wire logic output_enable_n,
	input wire logic sleep_control,
	input wire logic flow_through_sel_n,
	input wire logic flow_through_drv,
	input wire logic linear_order_sel_n,
	input wire logic linear_order_drv,
	input wire logic deselect_mode_sel,
	input wire logic deselect_mode_drv,
	input wire logic host_dq_oe_n,
	input wire logic dev_dq_oe_n
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// effective modes; an undriven pin means pipeline and single deselect
	wire logic ft = flow_through_drv && !flow_through_sel_n;
	wire logic dual = deselect_mode_drv && !deselect_mode_sel;
	wire logic strobe = !proc_addr_strobe_n || !ctrl_addr_strobe_n;
	wire logic wr = !global_write_n || (!byte_write_enable_n && !(&byte_lane_write_sel_n));
	wire logic start_rd = strobe && !chip_select_n && !wr && !sleep_control;
	wire logic desel = strobe && chip_select_n;
	// a drive is only owed while output enable is low and the part is awake
	wire logic drive_ok = output_enable_n || sleep_control || !dev_dq_oe_n;
	wire logic [5:0] modes = {flow_through_sel_n, flow_through_drv, linear_order_sel_n,
		linear_order_drv, deselect_mode_sel, deselect_mode_drv};

	sleep_off_a: assert property (sleep_control |-> dev_dq_oe_n)
		else $error("device drives dq while asleep");
	oe_off_a: assert property (output_enable_n |-> dev_dq_oe_n)
		else $error("device drives dq with output enable high");
	ft_read_a: assert property (start_rd && ft |=> drive_ok)
		else $error("flow-through read not driven next cycle");
	pipe_read_a: assert property (start_rd && !ft ##1 !strobe |=> drive_ok)
		else $error("pipelined read not driven two cycles on");
	scd_ft_a: assert property (desel && !dual && ft ##1 !strobe |-> dev_dq_oe_n)
		else $error("single deselect left flow-through output on");
	scd_pipe_a: assert property (desel && !dual && !ft ##1 !strobe [*2] |-> dev_dq_oe_n)
		else $error("single deselect left pipelined output on");
	dcd_pipe_a: assert property (desel && dual && !ft ##1 !strobe [*2] |=> dev_dq_oe_n)
		else $error("dual deselect left pipelined output on");
	host_drive_a: assert property (!host_dq_oe_n |-> wr)
		else $error("host drives dq outside a write");
	mode_static_a: assert property (!chip_select_n |-> $stable(modes))
		else $error("mode pins changed during an access");

	// main traffic shapes
	ft_read_c: cover property (start_rd && ft);
	dcd_c: cover property (desel && dual);
	sleep_c: cover property (sleep_control && !chip_select_n);
endmodule

/* tb/tb.sv */
`timescale 1ns/100ps
module tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [31:0] rd;
	int num_errors = 0;
	int checks = 0;
	localparam logic [31:0] BASE = 32'h0002_a5a0;

	sbsi_if bus ();
	sbsi_host sbsi_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bus(bus));
	sbsi_device sbsi_device_inst (.hclk(hclk), .hresetn(hresetn), .bus(bus));
	sbsi_checker sbsi_checker_inst (.hclk(hclk), .hresetn(hresetn),
		.chip_select_n(bus.chip_select_n), .proc_addr_strobe_n(bus.proc_addr_strobe_n),
		.ctrl_addr_strobe_n(bus.ctrl_addr_strobe_n),
		.byte_lane_write_sel_n(bus.byte_lane_write_sel_n),
		.byte_write_enable_n(bus.byte_write_enable_n), .global_write_n(bus.global_write_n),
		.output_enable_n(bus.output_enable_n), .sleep_control(bus.sleep_control),
		.flow_through_sel_n(bus.flow_through_sel_n), .flow_through_drv(bus.flow_through_drv),
		.linear_order_sel_n(bus.linear_order_sel_n), .linear_order_drv(bus.linear_order_drv),
		.deselect_mode_sel(bus.deselect_mode_sel), .deselect_mode_drv(bus.deselect_mode_drv),
		.host_dq_oe_n(bus.host_dq_oe_n), .dev_dq_oe_n(bus.dev_dq_oe_n));

	// 125 MHz
	always #4 hclk = ~hclk;

	task close_out;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			num_errors++;
		end
	endtask

	// one single-word transfer; waits on hready in both phases
	task xfer(input logic [4:0] a, input logic w, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {27'h0, a};
		htrans <= sbsi_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	// start a command and poll busy, bounded so a stuck sequencer shows up
	task run_cmd(input logic [31:0] cmd);
		int n;
		xfer(sbsi_pkg::OFS_CMD, 1'b1, cmd);
		n = 0;
		do begin
			xfer(sbsi_pkg::OFS_STATUS, 1'b0, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 40);
		chk("busy clear", 32'h0000_0000, rd & 32'h0000_0001);
	endtask

	task t_regs;
		xfer(sbsi_pkg::OFS_CTRL, 1'b0, 32'h0);
		chk("ctrl reset", 32'h0000_0000, rd);
		xfer(sbsi_pkg::OFS_STATUS, 1'b0, 32'h0);
		chk("status reset", 32'h0000_0000, rd);
		// the slave never stretches a phase and always answers okay
		chk("hreadyout", 32'h0000_0001, {31'h0, hreadyout});
		chk("hresp", 32'h0000_0000, {31'h0, hresp});
	endtask

	// four-beat global write from preset 0, so location 0x40+k holds BASE+k
	task t_fill;
		xfer(sbsi_pkg::OFS_CTRL, 1'b1, 32'h0);
		xfer(sbsi_pkg::OFS_ADDR, 1'b1, 32'h0000_0040);
		for (int k = 0; k < 4; k++)
			xfer(sbsi_pkg::OFS_DATA + 5'(4 * k), 1'b1, BASE + 32'(k));
		run_cmd(32'h0000_0033);
	endtask

	// four-beat read; beat order from the preset lsbs and the order select
	task t_order(input logic [31:0] ctrl, input logic [31:0] cmd, input logic [1:0] pre);
		logic [1:0] loc;
		xfer(sbsi_pkg::OFS_CTRL, 1'b1, ctrl);
		xfer(sbsi_pkg::OFS_ADDR, 1'b1, 32'h0000_0040 + {30'h0, pre});
		run_cmd(cmd);
		for (int k = 0; k < 4; k++) begin
			loc = ctrl[3] ? pre + 2'(k) : pre ^ 2'(k);
			xfer(sbsi_pkg::OFS_DATA + 5'(4 * k), 1'b0, 32'h0);
			chk("burst beat", BASE + {30'h0, loc}, rd);
		end
	endtask

	task t_bytes;
		xfer(sbsi_pkg::OFS_CTRL, 1'b1, 32'h0);
		xfer(sbsi_pkg::OFS_ADDR, 1'b1, 32'h0000_0041);
		xfer(sbsi_pkg::OFS_DATA, 1'b1, 32'h0003_ffff);
		run_cmd(32'h0000_0201);
		run_cmd(32'h0000_0000);
		xfer(sbsi_pkg::OFS_DATA, 1'b0, 32'h0);
		chk("upper lane only", ((BASE + 32'h1) & 32'h0000_01ff) | 32'h0003_fe00, rd);
		// global write with no lanes selected still writes both
		xfer(sbsi_pkg::OFS_DATA, 1'b1, 32'h0001_2345);
		run_cmd(32'h0000_0003);
		run_cmd(32'h0000_0000);
		xfer(sbsi_pkg::OFS_DATA, 1'b0, 32'h0);
		chk("global write", 32'h0001_2345, rd);
	endtask

	// asleep: write is dropped and a read sees an undriven bus
	task t_sleep;
		xfer(sbsi_pkg::OFS_CTRL, 1'b1, 32'h0000_0040);
		xfer(sbsi_pkg::OFS_DATA, 1'b1, 32'h0000_0abc);
		run_cmd(32'h0000_0003);
		run_cmd(32'h0000_0000);
		xfer(sbsi_pkg::OFS_DATA, 1'b0, 32'h0);
		chk("asleep read", 32'h0000_0000, rd);
		xfer(sbsi_pkg::OFS_CTRL, 1'b1, 32'h0);
		run_cmd(32'h0000_0000);
		xfer(sbsi_pkg::OFS_DATA, 1'b0, 32'h0);
		chk("kept over sleep", 32'h0001_2345, rd);
	endtask

	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs;
		t_fill;
		t_order(32'h0000_0000, 32'h0000_0030, 2'h1);
		t_order(32'h0000_000a, 32'h0000_0034, 2'h1);
		t_order(32'h0000_0020, 32'h0000_0030, 2'h2);
		t_order(32'h0000_002a, 32'h0000_0034, 2'h3);
		t_bytes;
		t_sleep;
		close_out;
	end

	// the whole run is a few hundred cycles; this margin only catches a hang
	initial begin
		repeat (20000) @(posedge hclk);
		num_errors++;
		close_out;
	end
endmodule
